//--- common/arss_pkg.sv
// Purpose: shared constants and types of the auto-reclose shot sequencer
// Assumes: 100 MHz ref_clk, timer settings given in milliseconds
// Notes: one tick of the internal timebase is one millisecond
package arss_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int NUM_SHOTS = 5;
    localparam int NUM_REQ = 4;
    localparam int CNT_W = 16;
    localparam int TIME_W = 19;
    localparam logic [TIME_W-1:0] RECLAIM_MIN_MS = 19'h00014;
    localparam logic [TIME_W-1:0] RECLAIM_MAX_MS = 19'h493e0;
    localparam logic [TIME_W-1:0] RECLAIM_DEF_MS = 19'h02710;
    localparam logic [TIME_W-1:0] DEAD_DEF_MS = 19'h01388;
    localparam logic [TIME_W-1:0] START_DEF_MS = 19'h00014;
    localparam logic [TIME_W-1:0] DISCR_DEF_MS = 19'h00014;
    localparam logic [2:0] SHOT_FIRST = 3'h1;
    localparam logic [2:0] SHOT_LAST = 3'h5;

    typedef enum logic [3:0] {
        ARSS_INIT, ARSS_RECLAIM, ARSS_READY, ARSS_START, ARSS_WAIT_OPEN, ARSS_DEAD,
        ARSS_WAIT_CLOSE, ARSS_DISCR, ARSS_LOCKED, ARSS_FINAL_TRIP, ARSS_CB_FAIL, ARSS_INHIBIT
    } arss_state_e;

    typedef enum logic [1:0] {
        TMR_RECLAIM, TMR_START, TMR_DEAD, TMR_DISCR
    } arss_timer_e;

    typedef enum logic [3:0] {
        OBJ_UNDEFINED, OBJ_OPEN, OBJ_CLOSE, OBJ_OPEN_REQUEST, OBJ_CLOSE_REQUEST,
        OBJ_READY, OBJ_NOT_READY, OBJ_INFO_NOT_AVAILABLE, OBJ_FAIL
    } arss_obj_e;
endpackage

//--- src/arss_timer.sv
// Purpose: millisecond down-counter with load and expiry pulse
// Assumes: tick is a one-cycle pulse every millisecond
// Notes: a load value of zero expires on the next tick
`timescale 1ns/1ps
module arss_timer #(
    parameter int W = 19
) (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic load, // restart with loadVal
    input wire logic [W-1:0] loadVal, // period in ms
    input wire logic tick, // ms tick
    output logic expired // one-cycle pulse at expiry
);
    logic [W-1:0] count_q, count_d;
    logic run_q, run_d;
    logic expired_d;

    // next count; load wins over a tick in the same cycle
    always_comb begin
        count_d = count_q;
        run_d = run_q;
        expired_d = 1'b0;
        if (load) begin
            count_d = loadVal;
            run_d = 1'b1;
        end else if (run_q && tick) begin
            if (count_q <= W'(1)) begin
                run_d = 1'b0;
                expired_d = 1'b1;
                count_d = '0;
            end else begin
                count_d = count_q - W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            run_q <= 1'b0;
            expired <= 1'b0;
        end else begin
            count_q <= count_d;
            run_q <= run_d;
            expired <= expired_d;
        end
    end
endmodule

//--- src/arss_sequencer.sv
// Purpose: auto-reclose shot sequencer driving breaker open and close coils
// Assumes: settings are static while a sequence runs; feedback is synchronous
// Notes: times in ms; settings are flat buses, shot n at slice n-1
`timescale 1ns/1ps
module arss_sequencer
    import arss_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int FAIL_MS = 1000
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic autoreclose_enable, // sequencer enabled
    input wire logic [NUM_REQ-1:0] reclose_request, // bit0 one, bit1 two, bits 2..3 others
    input wire logic breaker_is_open, // open position contact
    input wire logic breaker_is_closed, // closed position contact
    input wire logic close_block_input, // holds back reclose
    input wire logic [TIME_W-1:0] reclaim_time, // common reclaim time, ms
    input wire logic [NUM_SHOTS*TIME_W-1:0] shot_dead_time, // dead time per shot, ms
    input wire logic [NUM_SHOTS*NUM_REQ*TIME_W-1:0] shot_start_time, // start delay per shot and request
    input wire logic [NUM_SHOTS*NUM_REQ*TIME_W-1:0] shot_discr_time, // discrimination per shot and request
    input wire logic [NUM_SHOTS*NUM_REQ-1:0] shot_req_enable, // request enables per shot
    output logic breaker_open_output, // open coil command
    output logic breaker_close_output, // close coil command
    output arss_state_e sequencer_state, // sequencer state
    output logic [2:0] shot_index, // running shot 1..5
    output arss_timer_e active_timer_indicator, // running or last timer
    output arss_obj_e breaker_object_state, // breaker object state
    output logic [CNT_W-1:0] total_start_count, // all shot starts
    output logic [CNT_W-1:0] fail_count, // failed shots
    output logic [2*NUM_SHOTS*CNT_W-1:0] shot_start_count, // [req][shot] counters
    output logic sequence_done // pulse on successful reclaim
);
    localparam logic [TIME_W-1:0] FAIL_LIMIT = TIME_W'(FAIL_MS);

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick
    logic [31:0] div_q, div_d;
    logic tick_q, tick_d;
    always_comb begin
        div_d = div_q + 32'h1;
        tick_d = 1'b0;
        if (div_q >= 32'(TICK_DIV - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared phase timer
    logic tmrLoad;
    logic [TIME_W-1:0] tmrVal;
    logic tmrDone;
    arss_timer #(.W(TIME_W)) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(tmrLoad),
        .loadVal(tmrVal),
        .tick(tick_q),
        .expired(tmrDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // setting selection for the running shot and the latched request
    arss_state_e state_q, state_d;
    logic [2:0] shot_q, shot_d;
    logic [1:0] req_q, req_d;
    logic [2:0] shotSel;
    logic [NUM_REQ-1:0] shotEn, hitReq;
    logic [1:0] firstReq;
    logic anyHit, faultNow;
    logic [TIME_W-1:0] waitCnt_q, waitCnt_d;
    logic openCmd_q, openCmd_d, closeCmd_q, closeCmd_d;
    arss_timer_e tmr_q, tmr_d;
    logic done_d;
    logic [CNT_W-1:0] total_q, total_d, fail_q, fail_d;
    logic [CNT_W-1:0] sc_q [2*NUM_SHOTS];
    logic [CNT_W-1:0] sc_d [2*NUM_SHOTS];
    arss_obj_e obj_d;

    assign shotSel = shot_q - 3'h1;
    assign shotEn = shot_req_enable[shotSel*NUM_REQ +: NUM_REQ];
    assign hitReq = reclose_request & shotEn;
    assign anyHit = |hitReq;
    assign faultNow = reclose_request[req_q];

    // lowest enabled active request wins
    always_comb begin
        firstReq = 2'h0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (hitReq[i]) firstReq = 2'(i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_d = state_q;
        shot_d = shot_q;
        req_d = req_q;
        tmr_d = tmr_q;
        openCmd_d = openCmd_q;
        closeCmd_d = closeCmd_q;
        waitCnt_d = waitCnt_q;
        tmrLoad = 1'b0;
        tmrVal = '0;
        done_d = 1'b0;
        total_d = total_q;
        fail_d = fail_q;
        for (int k = 0; k < 2*NUM_SHOTS; k++) sc_d[k] = sc_q[k];
        if (tick_q && waitCnt_q != FAIL_LIMIT) waitCnt_d = waitCnt_q + TIME_W'(1);
        case (state_q)
            ARSS_INIT: begin
                state_d = autoreclose_enable ? ARSS_READY : ARSS_INHIBIT;
                shot_d = SHOT_FIRST;
            end
            ARSS_INHIBIT: begin
                if (autoreclose_enable) state_d = ARSS_READY;
            end
            ARSS_READY: begin
                if (!autoreclose_enable) begin
                    state_d = ARSS_INHIBIT;
                end else if (anyHit) begin
                    req_d = firstReq;
                    tmrLoad = 1'b1;
                    tmrVal = shot_start_time[(shotSel*NUM_REQ + 32'(firstReq))*TIME_W +: TIME_W];
                    tmr_d = TMR_START;
                    state_d = ARSS_START;
                    total_d = total_q + CNT_W'(1);
                    if (firstReq < 2'h2) begin
                        sc_d[32'(firstReq)*NUM_SHOTS + 32'(shotSel)] =
                            sc_q[32'(firstReq)*NUM_SHOTS + 32'(shotSel)] + CNT_W'(1);
                    end
                end
            end
            ARSS_START: begin
                if (!faultNow) begin
                    state_d = ARSS_READY;
                end else if (tmrDone) begin
                    openCmd_d = 1'b1;
                    waitCnt_d = '0;
                    state_d = ARSS_WAIT_OPEN;
                end
            end
            ARSS_WAIT_OPEN: begin
                if (breaker_is_open) begin
                    openCmd_d = 1'b0;
                    tmrLoad = 1'b1;
                    tmrVal = shot_dead_time[shotSel*TIME_W +: TIME_W];
                    tmr_d = TMR_DEAD;
                    waitCnt_d = '0;
                    state_d = ARSS_DEAD;
                end else if (waitCnt_q == FAIL_LIMIT) begin
                    openCmd_d = 1'b0;
                    state_d = ARSS_CB_FAIL;
                end
            end
            ARSS_DEAD: begin
                // no coil timed here; waitCnt at the limit latches dead-time expiry while blocked
                waitCnt_d = (tmrDone || waitCnt_q == FAIL_LIMIT) ? FAIL_LIMIT : '0;
                if (waitCnt_d == FAIL_LIMIT && !close_block_input) begin
                    closeCmd_d = 1'b1;
                    waitCnt_d = '0;
                    state_d = ARSS_WAIT_CLOSE;
                end
            end
            ARSS_WAIT_CLOSE: begin
                if (breaker_is_closed) begin
                    closeCmd_d = 1'b0;
                    tmrLoad = 1'b1;
                    tmrVal = shot_discr_time[(shotSel*NUM_REQ + 32'(req_q))*TIME_W +: TIME_W];
                    tmr_d = TMR_DISCR;
                    state_d = ARSS_DISCR;
                end else if (waitCnt_q == FAIL_LIMIT) begin
                    closeCmd_d = 1'b0;
                    state_d = ARSS_CB_FAIL;
                end
            end
            ARSS_DISCR: begin
                if (!faultNow) begin
                    tmrLoad = 1'b1;
                    tmrVal = reclaim_time < RECLAIM_MIN_MS ? RECLAIM_MIN_MS :
                             reclaim_time > RECLAIM_MAX_MS ? RECLAIM_MAX_MS : reclaim_time;
                    tmr_d = TMR_RECLAIM;
                    state_d = ARSS_RECLAIM;
                end else if (tmrDone) begin
                    fail_d = fail_q + CNT_W'(1);
                    if (shot_q == SHOT_LAST) begin
                        openCmd_d = 1'b1;
                        state_d = ARSS_FINAL_TRIP;
                    end else begin
                        openCmd_d = 1'b1;
                        waitCnt_d = '0;
                        shot_d = shot_q + 3'h1;
                        total_d = total_q + CNT_W'(1);
                        if (req_q < 2'h2) begin
                            sc_d[32'(req_q)*NUM_SHOTS + 32'(shot_q)] =
                                sc_q[32'(req_q)*NUM_SHOTS + 32'(shot_q)] + CNT_W'(1);
                        end
                        state_d = ARSS_WAIT_OPEN;
                    end
                end
            end
            ARSS_RECLAIM: begin
                if (tmrDone) begin
                    done_d = 1'b1;
                    shot_d = SHOT_FIRST;
                    state_d = ARSS_READY;
                end
            end
            ARSS_FINAL_TRIP: begin
                if (breaker_is_open) begin
                    openCmd_d = 1'b0;
                    state_d = ARSS_LOCKED;
                end
            end
            ARSS_LOCKED, ARSS_CB_FAIL: begin
                // leaves only when disabled, to inhibit
                if (!autoreclose_enable) begin
                    shot_d = SHOT_FIRST;
                    state_d = ARSS_INHIBIT;
                end
            end
            default: state_d = ARSS_INIT;
        endcase
    end

    // breaker object state from contacts and pending commands
    always_comb begin
        if (state_q == ARSS_CB_FAIL) obj_d = OBJ_FAIL;
        else if (openCmd_d) obj_d = OBJ_OPEN_REQUEST;
        else if (closeCmd_d) obj_d = OBJ_CLOSE_REQUEST;
        else if (breaker_is_open && breaker_is_closed) obj_d = OBJ_UNDEFINED;
        else if (breaker_is_open) obj_d = OBJ_OPEN;
        else if (breaker_is_closed) obj_d = OBJ_CLOSE;
        else obj_d = OBJ_INFO_NOT_AVAILABLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ARSS_INIT;
            shot_q <= SHOT_FIRST;
            req_q <= 2'h0;
            tmr_q <= TMR_RECLAIM;
            openCmd_q <= 1'b0;
            closeCmd_q <= 1'b0;
            waitCnt_q <= '0;
            total_q <= '0;
            fail_q <= '0;
            for (int k = 0; k < 2*NUM_SHOTS; k++) sc_q[k] <= '0;
            sequence_done <= 1'b0;
            breaker_object_state <= OBJ_UNDEFINED;
        end else begin
            state_q <= state_d;
            shot_q <= shot_d;
            req_q <= req_d;
            tmr_q <= tmr_d;
            openCmd_q <= openCmd_d;
            closeCmd_q <= closeCmd_d;
            waitCnt_q <= waitCnt_d;
            total_q <= total_d;
            fail_q <= fail_d;
            for (int k = 0; k < 2*NUM_SHOTS; k++) sc_q[k] <= sc_d[k];
            sequence_done <= done_d;
            breaker_object_state <= obj_d;
        end
    end

    // outputs straight from state registers
    assign breaker_open_output = openCmd_q;
    assign breaker_close_output = closeCmd_q;
    assign sequencer_state = state_q;
    assign shot_index = shot_q;
    assign active_timer_indicator = tmr_q;
    assign total_start_count = total_q;
    assign fail_count = fail_q;
    for (genvar g = 0; g < 2*NUM_SHOTS; g++) begin : g_sc
        assign shot_start_count[g*CNT_W +: CNT_W] = sc_q[g];
    end
endmodule

//--- bench/arss_breaker_model.sv
// Purpose: behavioural circuit breaker with open and close coils
// Assumes: coils are levels held until the matching contact reports
// Notes: stuck freezes the mechanism so the coil timeout can be reached
`timescale 1ns/1ps
module arss_breaker_model #(
    parameter int TRAVEL = 5
) (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic openCmd, // open coil
    input wire logic closeCmd, // close coil
    input wire logic stuck, // mechanism jammed
    output logic isOpen, // open contact
    output logic isClosed // closed contact
);
    logic posOpen_q;
    int travel_q;

    // coil must stay energised for the whole travel, a dropped coil restarts it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            posOpen_q <= 1'b0;
            travel_q <= 0;
        end else if (!stuck && ((openCmd && !posOpen_q) || (closeCmd && posOpen_q))) begin
            travel_q <= travel_q + 1;
            if (travel_q == TRAVEL - 1) begin
                posOpen_q <= !posOpen_q;
                travel_q <= 0;
            end
        end else begin
            travel_q <= 0;
        end
    end

    // neither contact made while the mechanism is moving
    assign isOpen = posOpen_q && (travel_q == 0);
    assign isClosed = !posOpen_q && (travel_q == 0);
endmodule

//--- bench/arss_monitor.sv
// Purpose: concurrent checks on the shot sequencer ports
// Assumes: single ref_clk domain, rst_n async active low
// Notes: bound to every arss_sequencer instance
`timescale 1ns/1ps
module arss_monitor
    import arss_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic breaker_is_open, // open contact
    input wire logic breaker_is_closed, // closed contact
    input wire logic close_block_input, // close hold-back
    input wire logic breaker_open_output, // open coil
    input wire logic breaker_close_output, // close coil
    input wire arss_state_e sequencer_state, // state
    input wire logic [2:0] shot_index, // running shot
    input wire arss_timer_e active_timer_indicator, // running timer
    input wire logic [CNT_W-1:0] total_start_count, // all starts
    input wire logic sequence_done // success pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // coil commands against state and contacts
    property p_open_rise;
        $rose(breaker_open_output) |-> sequencer_state inside {ARSS_WAIT_OPEN, ARSS_FINAL_TRIP};
    endproperty
    a_open_rise: assert property (p_open_rise) else $error("open coil raised outside wait-open or final trip");
    property p_open_done;
        sequencer_state == ARSS_WAIT_OPEN && breaker_is_open |=>
            !breaker_open_output && sequencer_state == ARSS_DEAD && active_timer_indicator == TMR_DEAD;
    endproperty
    a_open_done: assert property (p_open_done) else $error("open contact did not start dead time");
    property p_close_done;
        sequencer_state == ARSS_WAIT_CLOSE && breaker_is_closed |=>
            !breaker_close_output && sequencer_state == ARSS_DISCR && active_timer_indicator == TMR_DISCR;
    endproperty
    a_close_done: assert property (p_close_done) else $error("closed contact did not start discrimination");
    property p_close_rise;
        $rose(breaker_close_output) |-> sequencer_state == ARSS_WAIT_CLOSE && !$past(close_block_input);
    endproperty
    a_close_rise: assert property (p_close_rise) else $error("close coil raised while blocked");
    property p_block_hold;
        close_block_input && !breaker_close_output |=> !breaker_close_output;
    endproperty
    a_block_hold: assert property (p_block_hold) else $error("close coil raised under block");

    ////////////////////////////////////////////////////////////////////////////
    // shot index and counters
    property p_shot_range;
        shot_index >= SHOT_FIRST && shot_index <= SHOT_LAST;
    endproperty
    a_shot_range: assert property (p_shot_range) else $error("shot index out of range");
    property p_advance;
        sequencer_state == ARSS_DISCR ##1 sequencer_state == ARSS_WAIT_OPEN |-> shot_index == $past(shot_index) + 3'h1;
    endproperty
    a_advance: assert property (p_advance) else $error("reopen did not advance the shot");
    property p_count_step;
        total_start_count != $past(total_start_count) |-> total_start_count == $past(total_start_count) + 16'h1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("start counter jumped");
    property p_done;
        sequence_done |-> shot_index == SHOT_FIRST ##1 !sequence_done;
    endproperty
    a_done: assert property (p_done) else $error("success pulse without shot one");

    // main scenarios reached
    c_done: cover property (sequence_done);
    c_locked: cover property (sequencer_state == ARSS_LOCKED);
    c_cb_fail: cover property (sequencer_state == ARSS_CB_FAIL);
endmodule

bind arss_sequencer arss_monitor i_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .breaker_is_open(breaker_is_open),
    .breaker_is_closed(breaker_is_closed), .close_block_input(close_block_input),
    .breaker_open_output(breaker_open_output), .breaker_close_output(breaker_close_output),
    .sequencer_state(sequencer_state), .shot_index(shot_index), .active_timer_indicator(active_timer_indicator),
    .total_start_count(total_start_count), .sequence_done(sequence_done));

//--- bench/autoreclose_shot_sequencer_tb.sv
// Purpose: self-checking bench of the shot sequencer against a breaker model
// Assumes: 1 ms tick shortened to 10 cycles, coil timeout to 5 ms
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module autoreclose_shot_sequencer_tb
    import arss_pkg::*;
;
    typedef struct {int req; int nf; int totInc; int failInc;} arss_row_s;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic autoreclose_enable = 1'b1;
    logic close_block_input = 1'b0;
    logic stuck = 1'b0;
    logic [NUM_REQ-1:0] reclose_request = 4'h0;
    logic breaker_is_open, breaker_is_closed, breaker_open_output, breaker_close_output, sequence_done;
    arss_state_e sequencer_state;
    arss_timer_e active_timer_indicator;
    arss_obj_e breaker_object_state;
    logic [2:0] shot_index;
    logic [CNT_W-1:0] total_start_count, fail_count;
    logic [2*NUM_SHOTS*CNT_W-1:0] shot_start_count;
    int badCount = 0;
    int compares = 0;
    int expTot = 0;
    int expFail = 0;
    int expShot[10] = '{default: 0};
    arss_row_s rows[4] = '{'{0, 0, 1, 0}, '{1, 1, 2, 1}, '{0, 3, 4, 3}, '{1, 2, 3, 2}};

    always #5 ref_clk = ~ref_clk;

    // short times keep each shot near a hundred cycles
    arss_sequencer #(.TICK_DIV(10), .FAIL_MS(5)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .autoreclose_enable(autoreclose_enable), .reclose_request(reclose_request),
        .breaker_is_open(breaker_is_open), .breaker_is_closed(breaker_is_closed),
        .close_block_input(close_block_input), .reclaim_time(RECLAIM_MIN_MS),
        .shot_dead_time({19'h00007, 19'h00006, 19'h00005, 19'h00004, 19'h00003}),
        .shot_start_time({20{19'h00002}}), .shot_discr_time({20{19'h00002}}), .shot_req_enable(20'hfffff),
        .breaker_open_output(breaker_open_output), .breaker_close_output(breaker_close_output),
        .sequencer_state(sequencer_state), .shot_index(shot_index), .active_timer_indicator(active_timer_indicator),
        .breaker_object_state(breaker_object_state), .total_start_count(total_start_count),
        .fail_count(fail_count), .shot_start_count(shot_start_count), .sequence_done(sequence_done));
    arss_breaker_model i_breaker (.ref_clk(ref_clk), .rst_n(rst_n), .openCmd(breaker_open_output),
        .closeCmd(breaker_close_output), .stuck(stuck), .isOpen(breaker_is_open), .isClosed(breaker_is_closed));

    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded poll on the falling edge, a miss counts as a mismatch
    task waitFor(input int what, input logic val, input int maxc);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < maxc && !hit; n++) begin
            @(negedge ref_clk);
            case (what)
                0: hit = (breaker_close_output === val);
                1: hit = (sequence_done === val);
                2: hit = (breaker_is_open === val);
                3: hit = ((sequencer_state === ARSS_LOCKED) === val);
                4: hit = ((sequencer_state === ARSS_CB_FAIL) === val);
                5: hit = ((sequencer_state === ARSS_INHIBIT) === val);
                default: hit = ((sequencer_state === ARSS_READY) === val);
            endcase
        end
        check(16'(hit), 16'h0001);
    endtask

    task checkCounts();
        check(total_start_count, 16'(expTot));
        check(fail_count, 16'(expFail));
        for (int k = 0; k < 10; k++) check(shot_start_count[k*CNT_W +: CNT_W], 16'(expShot[k]));
    endtask

    // fault held through nf reopenings, dropped during the last reclose
    task runSeq(input int req, input int nf);
        reclose_request[req] = 1'b1;
        for (int i = 0; i <= nf; i++) begin
            waitFor(0, 1'b1, 400);
            if (i == nf) reclose_request[req] = 1'b0;
            waitFor(0, 1'b0, 200);
        end
        waitFor(1, 1'b1, 600);
        check(16'(shot_index), 16'h0001);
        waitFor(6, 1'b1, 5);
        for (int k = 0; k <= nf; k++) expShot[req*NUM_SHOTS+k]++;
    endtask

    task endOfTest();
        $display("comparisons %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        badCount++;
        endOfTest();
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        waitFor(6, 1'b1, 3);
        // ordinary sequences, one row each
        foreach (rows[i]) begin
            runSeq(rows[i].req, rows[i].nf);
            expTot += rows[i].totInc;
            expFail += rows[i].failInc;
            checkCounts();
            $display("row %0d done", i);
        end
        // close held back well past the dead time, then issued at once
        close_block_input = 1'b1;
        reclose_request[1] = 1'b1;
        waitFor(2, 1'b1, 200);
        repeat (80) @(negedge ref_clk);
        check(16'(breaker_close_output), 16'h0000);
        check(16'(active_timer_indicator), 16'(TMR_DEAD));
        close_block_input = 1'b0;
        @(negedge ref_clk);
        check(16'(breaker_close_output), 16'h0001);
        reclose_request[1] = 1'b0;
        waitFor(1, 1'b1, 600);
        expTot++;
        expShot[5]++;
        checkCounts();
        $display("block test done");
        // fault never clears: five shots, final trip, lock
        reclose_request[0] = 1'b1;
        waitFor(3, 1'b1, 3000);
        expTot += 5;
        expFail += 5;
        for (int k = 0; k < 5; k++) expShot[k]++;
        checkCounts();
        check(16'(breaker_is_open), 16'h0001);
        reclose_request[0] = 1'b0;
        $display("final trip test done");
        // reset in mid-run clears everything
        rst_n = 1'b0;
        @(negedge ref_clk);
        check(16'(sequencer_state), 16'(ARSS_INIT));
        check(16'(shot_index), 16'h0001);
        check(16'(breaker_object_state), 16'(OBJ_UNDEFINED));
        check(16'({breaker_open_output, breaker_close_output}), 16'h0000);
        check(total_start_count, 16'h0000);
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        waitFor(6, 1'b1, 3);
        $display("reset test done");
        // request dropped inside the start delay gives no open command
        reclose_request[0] = 1'b1;
        repeat (5) @(negedge ref_clk);
        reclose_request[0] = 1'b0;
        repeat (40) @(negedge ref_clk);
        check(16'(breaker_open_output), 16'h0000);
        check(16'(sequencer_state), 16'(ARSS_READY));
        $display("refusal test done");
        // jammed breaker runs into the coil timeout, then inhibit
        stuck = 1'b1;
        reclose_request[0] = 1'b1;
        waitFor(4, 1'b1, 300);
        reclose_request[0] = 1'b0;
        autoreclose_enable = 1'b0;
        waitFor(5, 1'b1, 5);
        $display("breaker fail test done");
        endOfTest();
    end
endmodule
